// ### design/power_clock_result_regs.sv
`timescale 1ns/100ps
//
// Behaviour
// R1 - transmitter off in dynamic power-down when set
// R2 - range bit picks 50mA or 100mA full scale
// R3 - converter off in dynamic power-down when set
// R4 - oscillator select clear: external clock, pin input
// R5 - oscillator select set: internal 4 MHz source
// R6 - amplifier off in dynamic power-down when set
// R7 - rest of converter off in dynamic power-down
// R8 - receive power-off bit powers down receive path
// R9 - full power-off bit powers down whole front end
// R10 - clock output enable drives internal clock onto pin
// R11 - pin clock divided by two to the code
// R12 - second LED result read-only 24-bit, reset zero
// R13 - one register shows ambient-2 or third LED result
// R14 - three-LED mode selects third LED result there
// R15 - LED current codes 6-bit, 63 is full scale
//
module power_clock_result_regs (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // register port
    input wire logic [7:0] regAddr,
    input wire logic [23:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [23:0] regRdData,
    // conversion results from the converter
    input wire logic [23:0] secondLedResult,
    input wire logic [23:0] secondAmbientResult,
    input wire logic [23:0] thirdLedResult,
    input wire logic resultStrobe,
    input wire logic threeLedMode,
    // dynamic power-down interval from the timing engine
    input wire logic dynPowerDownActive,
    // first led current code from the current register
    input wire logic [5:0] firstLedCurrentCode,
    // power controls to the analog front end
    output logic transmitterPowerOff,
    output logic converterPowerOff,
    output logic amplifierPowerOff,
    output logic converterRestPowerOff,
    output logic receivePathPowerOff,
    output logic frontEndPowerOff,
    output logic highCurrentRange,
    output logic [6:0] firstLedCurrentMilliamp,
    // clocking
    output logic oscillatorEnable,
    output logic clockPinOut,
    output logic clockPinOutEn,
    output logic clockDividerCodeBad
);

    ////////////////////////////////////////////////////////////////////
    // registers
    logic [23:0] powerCtrl_q; // power-down and clock select
    logic [23:0] clockOut_q; // clock output control
    logic [23:0] led2Result_q; // latched second led result
    logic [23:0] sharedResult_q; // ambient-2 or third led result
    logic [23:0] rdData_q; // read data, valid one cycle after strobe
    logic [23:0] rdData_d;
    logic [23:0] sharedResult_d;

    // address decode
    logic hitPower;
    logic hitClock;
    logic hitLed2;
    logic hitShared;
    assign hitPower = regAddr == pwr_clk_pkg::PowerCtrlAddr;
    assign hitClock = regAddr == pwr_clk_pkg::ClockOutAddr;
    assign hitLed2 = regAddr == pwr_clk_pkg::Led2ResultAddr;
    assign hitShared = regAddr == pwr_clk_pkg::AmbOrLed3ResultAddr;

    // read mux; unmapped addresses read as zero
    assign rdData_d = hitPower ? powerCtrl_q :
                      hitClock ? clockOut_q :
                      hitLed2 ? led2Result_q :
                      hitShared ? sharedResult_q :
                      pwr_clk_pkg::RegReset;
    assign regRdData = rdData_q;

    // control register writes; reserved bits stay zero
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            powerCtrl_q <= pwr_clk_pkg::RegReset;
            clockOut_q <= pwr_clk_pkg::RegReset;
        end else if (regWrite) begin
            if (hitPower) begin
                powerCtrl_q <= regWrData & pwr_clk_pkg::PowerCtrlMask;
            end
            if (hitClock) begin
                clockOut_q <= regWrData & pwr_clk_pkg::ClockOutMask;
            end
        end
    end

    // read data register; stands only in the cycle after the strobe
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rdData_q <= pwr_clk_pkg::RegReset;
        end else if (regRead) begin
            rdData_q <= rdData_d;
        end else begin
            rdData_q <= pwr_clk_pkg::RegReset;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // results: writes to these addresses are ignored
    // mode chosen at capture so a read never mixes two conversions
    assign sharedResult_d = threeLedMode ? thirdLedResult // R14
                                         : secondAmbientResult; // R13

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            led2Result_q <= pwr_clk_pkg::RegReset; // R12
            sharedResult_q <= pwr_clk_pkg::RegReset;
        end else if (resultStrobe) begin
            led2Result_q <= secondLedResult; // R12
            sharedResult_q <= sharedResult_d; // R13
        end
    end

    ////////////////////////////////////////////////////////////////////
    // power controls
    logic dynTransmitterOff;
    logic dynConverterOff;
    logic dynAmplifierOff;
    logic dynConverterRestOff;
    logic receivePathOff;
    logic frontEndOff;
    assign dynTransmitterOff =
        powerCtrl_q[pwr_clk_pkg::DynTransmitterOffBit];
    assign dynConverterOff = powerCtrl_q[pwr_clk_pkg::DynConverterOffBit];
    assign dynAmplifierOff = powerCtrl_q[pwr_clk_pkg::DynAmplifierOffBit];
    assign dynConverterRestOff =
        powerCtrl_q[pwr_clk_pkg::DynConverterRestOffBit];
    assign receivePathOff = powerCtrl_q[pwr_clk_pkg::ReceivePathOffBit];
    assign frontEndOff = powerCtrl_q[pwr_clk_pkg::FrontEndOffBit];

    // full power-off overrides every other control
    assign transmitterPowerOff = frontEndOff
        | (dynTransmitterOff & dynPowerDownActive); // R1
    assign converterPowerOff = frontEndOff
        | (dynConverterOff & dynPowerDownActive); // R3
    assign amplifierPowerOff = frontEndOff | receivePathOff
        | (dynAmplifierOff & dynPowerDownActive); // R6 R8
    assign converterRestPowerOff = frontEndOff
        | (dynConverterRestOff & dynPowerDownActive); // R7
    assign receivePathPowerOff = frontEndOff | receivePathOff; // R8 R9
    assign frontEndPowerOff = frontEndOff; // R9

    ////////////////////////////////////////////////////////////////////
    // led current range and current estimate
    assign highCurrentRange =
        powerCtrl_q[pwr_clk_pkg::LedCurrentRangeBit]; // R2
    // full scale current scaled by code / 63, rounded down
    logic [13:0] milliampProduct;
    logic [6:0] fullScale;
    assign fullScale = highCurrentRange
        ? 7'(pwr_clk_pkg::HighRangeFullMilliamp)
        : 7'(pwr_clk_pkg::LowRangeFullMilliamp); // R2
    assign milliampProduct = 14'(firstLedCurrentCode) * 14'(fullScale);
    assign firstLedCurrentMilliamp =
        7'(milliampProduct / 14'(pwr_clk_pkg::LedCodeFull)); // R15

    ////////////////////////////////////////////////////////////////////
    // clock source selection
    logic oscSelect;
    assign oscSelect =
        powerCtrl_q[pwr_clk_pkg::InternalOscillatorSelectBit];
    // oscillator idles in external mode; pin is then an input
    assign oscillatorEnable = oscSelect & ~frontEndOff; // R4 R5

    // 4 MHz oscillator modelled as half-period ticks of the system clock
    logic [4:0] tickCount_q;
    logic halfTick;
    assign halfTick =
        tickCount_q == 5'(pwr_clk_pkg::HalfTickCycles - 1);

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            tickCount_q <= 5'h00;
        end else if (!oscillatorEnable || halfTick) begin
            tickCount_q <= 5'h00;
        end else begin
            tickCount_q <= tickCount_q + 5'h01; // R5
        end
    end

    ////////////////////////////////////////////////////////////////////
    // clock pin output
    logic clockPinEnable;
    logic [3:0] dividerCode;
    assign clockPinEnable = oscillatorEnable
        & clockOut_q[pwr_clk_pkg::ClockPinOutputEnableBit]; // R10
    assign dividerCode = clockOut_q[pwr_clk_pkg::ClockPinDividerLsb
        +: pwr_clk_pkg::ClockPinDividerWidth];
    // forbidden codes are flagged; output then runs at the slowest rate
    assign clockDividerCodeBad =
        dividerCode > pwr_clk_pkg::DividerCodeMax; // R11
    logic [3:0] safeCode;
    assign safeCode = clockDividerCodeBad ? pwr_clk_pkg::DividerCodeMax
                                          : dividerCode;
    // pin only driven in oscillator mode, otherwise it takes a clock in
    assign clockPinOutEn = clockPinEnable; // R4 R10

    clock_pin_divider_gen #(
        .CodeWidth(4),
        .StageCount(8)
    ) divider (
        .sysClk(sys_clk),
        .rst(rst),
        .enable(clockPinEnable),
        .halfTick(halfTick),
        .divCode(safeCode), // R11
        .clockPinOut(clockPinOut)
    );

endmodule

// ### shared/pwr_clk_pkg.sv
package pwr_clk_pkg;
    // register offsets (word index on the plain port)
    localparam logic [7:0] PowerCtrlAddr = 8'h23;
    localparam logic [7:0] ClockOutAddr = 8'h29;
    localparam logic [7:0] Led2ResultAddr = 8'h2a;
    localparam logic [7:0] AmbOrLed3ResultAddr = 8'h2b;
    // register width and reset
    localparam int RegWidth = 24;
    localparam logic [23:0] RegReset = 24'h000000;
    // power-down and clock select field positions
    localparam int DynTransmitterOffBit = 20;
    localparam int LedCurrentRangeBit = 17;
    localparam int DynConverterOffBit = 14;
    localparam int InternalOscillatorSelectBit = 9;
    localparam int DynAmplifierOffBit = 4;
    localparam int DynConverterRestOffBit = 3;
    localparam int ReceivePathOffBit = 1;
    localparam int FrontEndOffBit = 0;
    // writable mask of the power-down register
    localparam logic [23:0] PowerCtrlMask = 24'h12421b;
    // clock output register fields
    localparam int ClockPinOutputEnableBit = 9;
    localparam int ClockPinDividerLsb = 1;
    localparam int ClockPinDividerWidth = 4;
    localparam logic [23:0] ClockOutMask = 24'h00021e;
    // largest legal divider code
    localparam logic [3:0] DividerCodeMax = 4'h7;
    // led current code width and full scale code
    localparam int LedCodeWidth = 6;
    localparam logic [5:0] LedCodeFull = 6'h3f;
    // full-scale currents in milliamps for each range setting
    localparam int LowRangeFullMilliamp = 50;
    localparam int HighRangeFullMilliamp = 100;
    // clock rates: system clock and the internal oscillator
    localparam int SysClockHz = 100000000;
    localparam int OscillatorHz = 4000000;
    localparam int OscTickCycles = SysClockHz / OscillatorHz;
    localparam int HalfTickCycles = OscTickCycles / 2;
endpackage

// ### design/clock_pin_divider_gen.sv
`timescale 1ns/100ps
// divides the oscillator tick rate by 2**code and drives a square wave
module clock_pin_divider_gen #(
    parameter int CodeWidth = 4,
    parameter int StageCount = 8
) (
    // clock and reset
    input wire logic sysClk,
    input wire logic rst,
    // control
    input wire logic enable,
    input wire logic halfTick,
    input wire logic [CodeWidth-1:0] divCode,
    // output
    output logic clockPinOut
);
    // ripple count of half-oscillator ticks
    logic [StageCount-1:0] stageCount_q;
    logic [StageCount-1:0] stageCount_d;
    logic toggleNow;
    // ones in the stages below the chosen code
    logic [StageCount-1:0] lowMask;
    logic clockPin_q;

    assign stageCount_d = stageCount_q + {{(StageCount-1){1'b0}}, 1'b1};
    assign lowMask = StageCount'((32'h1 << divCode) - 32'h1);
    // toggle when all count bits below the chosen stage are ones
    assign toggleNow = halfTick & (&(stageCount_q | ~lowMask));
    assign clockPinOut = clockPin_q;

    // counter runs only while enabled, so output restarts cleanly low
    always_ff @(posedge sysClk or posedge rst) begin
        if (rst) begin
            stageCount_q <= '0;
            clockPin_q <= 1'b0;
        end else if (!enable) begin
            stageCount_q <= '0;
            clockPin_q <= 1'b0;
        end else if (halfTick) begin
            stageCount_q <= stageCount_d;
            if (toggleNow) begin
                clockPin_q <= ~clockPin_q;
            end
        end
    end
endmodule

// ### verif/power_clock_result_regs_props.sv
`timescale 1ns/100ps
// watches the register port and the control outputs against a shadow copy
module power_clock_result_regs_props (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // register port
    input wire logic [7:0] regAddr,
    input wire logic [23:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [23:0] regRdData,
    // front end side
    input wire logic dynPowerDownActive,
    input wire logic transmitterPowerOff,
    input wire logic converterPowerOff,
    input wire logic amplifierPowerOff,
    input wire logic converterRestPowerOff,
    input wire logic receivePathPowerOff,
    input wire logic frontEndPowerOff,
    input wire logic oscillatorEnable,
    input wire logic clockPinOutEn,
    input wire logic clockDividerCodeBad
);
    logic [23:0] pwr_q; // shadow of the power-down register
    logic [23:0] clk_q; // shadow of the clock output register
    wire logic dyn = dynPowerDownActive;
    ////////////////////////////////////////////////////////////////////////
    // shadow registers follow the writes, masked as the design keeps them
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pwr_q <= 24'h000000;
            clk_q <= 24'h000000;
        end else if (regWrite && regAddr == pwr_clk_pkg::PowerCtrlAddr) begin
            pwr_q <= regWrData & pwr_clk_pkg::PowerCtrlMask;
        end else if (regWrite && regAddr == pwr_clk_pkg::ClockOutAddr) begin
            clk_q <= regWrData & pwr_clk_pkg::ClockOutMask;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    a_rdata_quiet: assert property (!regRead |=> regRdData == 24'h000000)
        else $error("read data not zero");
    a_tx_dyn_off: assert property (
        transmitterPowerOff == ((pwr_q[20] & dyn) | pwr_q[0])) else $error("tx");
    a_conv_dyn_off: assert property (
        converterPowerOff == ((pwr_q[14] & dyn) | pwr_q[0])) else $error("adc");
    a_amp_dyn_off: assert property (
        amplifierPowerOff == ((pwr_q[4] & dyn) | pwr_q[1] | pwr_q[0]))
        else $error("amp");
    a_rest_dyn_off: assert property (
        converterRestPowerOff == ((pwr_q[3] & dyn) | pwr_q[0])) else $error("rest");
    a_rx_off: assert property (
        receivePathPowerOff == (pwr_q[1] | pwr_q[0])) else $error("rx");
    a_fe_off: assert property (
        frontEndPowerOff == pwr_q[0]) else $error("front end");
    a_osc_select: assert property (
        oscillatorEnable == (pwr_q[9] & ~pwr_q[0])) else $error("osc");
    a_pin_enable: assert property (
        clockPinOutEn == (oscillatorEnable & clk_q[9])) else $error("pin en");
    a_code_flag: assert property (
        clockDividerCodeBad == (clk_q[4:1] > 4'h7)) else $error("div flag");
    c_pwr_write: cover property (regWrite && regAddr == 8'h23);
    c_amb_read: cover property (regRead && regAddr == 8'h2b);
    c_pin_on: cover property ($rose(clockPinOutEn));
endmodule
bind power_clock_result_regs power_clock_result_regs_props i_props (
    .sys_clk, .rst, .regAddr, .regWrData, .regWrite, .regRead, .regRdData,
    .dynPowerDownActive, .transmitterPowerOff, .converterPowerOff,
    .amplifierPowerOff, .converterRestPowerOff, .receivePathPowerOff,
    .frontEndPowerOff, .oscillatorEnable, .clockPinOutEn, .clockDividerCodeBad);

// ### verif/tb_top.sv
`timescale 1ns/100ps
module tb_top;
    logic sys_clk, rst, regWrite, regRead, resultStrobe, threeLedMode;
    logic dynPowerDownActive, transmitterPowerOff, converterPowerOff;
    logic amplifierPowerOff, converterRestPowerOff, receivePathPowerOff;
    logic frontEndPowerOff, highCurrentRange, oscillatorEnable;
    logic clockPinOut, clockPinOutEn, clockDividerCodeBad;
    logic [7:0] regAddr;
    logic [23:0] regWrData, regRdData, thirdLedResult;
    logic [23:0] secondLedResult, secondAmbientResult;
    logic [5:0] firstLedCurrentCode;
    logic [6:0] firstLedCurrentMilliamp;
    int err_count = 0;
    int total_checks = 0;
    power_clock_result_regs i_power_clock_result_regs (.*);
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one-cycle write strobe, launched just after an edge
    task automatic wr(input logic [7:0] a, input logic [23:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regWrData <= d;
        regWrite <= 1'b1;
        @(posedge sys_clk);
        regWrite <= 1'b0;
        #1;
    endtask
    // read data only stand in the cycle after the strobe
    task automatic rdChk(input logic [7:0] a, input logic [23:0] exp);
        @(posedge sys_clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge sys_clk);
        regRead <= 1'b0;
        #1 chk(regRdData, exp);
    endtask
    function automatic logic [23:0] pv();
        return {18'h0, transmitterPowerOff, converterPowerOff,
            amplifierPowerOff, converterRestPowerOff, receivePathPowerOff,
            frontEndPowerOff};
    endfunction
    ////////////////////////////////////////////////////////////////////////
    task automatic test_power();
        wr(8'h23, 24'hffffff);
        rdChk(8'h23, 24'h12421b);
        wr(8'h23, 24'h12421a);
        #1 chk(pv(), 24'h0a);
        @(posedge sys_clk) dynPowerDownActive <= 1'b1;
        #1 chk(pv(), 24'h3e);
        wr(8'h23, 24'h000001);
        #1 chk(pv(), 24'h3f);
        wr(8'h23, 24'h000000);
        #1 chk(pv(), 24'h00);
        wr(8'h40, 24'hffffff);
        rdChk(8'h40, 24'h000000);
    endtask
    task automatic test_results();
        @(posedge sys_clk);
        secondLedResult <= 24'h800001;
        secondAmbientResult <= 24'h7ffffe;
        thirdLedResult <= 24'h123456;
        resultStrobe <= 1'b1;
        @(posedge sys_clk) resultStrobe <= 1'b0;
        rdChk(8'h2a, 24'h800001);
        rdChk(8'h2b, 24'h7ffffe);
        @(posedge sys_clk);
        threeLedMode <= 1'b1;
        resultStrobe <= 1'b1;
        @(posedge sys_clk) resultStrobe <= 1'b0;
        rdChk(8'h2b, 24'h123456);
        wr(8'h2a, 24'h000000);
        rdChk(8'h2a, 24'h800001);
    endtask
    // counts one full half period of the pin clock for a divider code
    task automatic halfChk(input logic [3:0] code);
        int n;
        logic last;
        wr(8'h29, 24'h000200 | {19'h0, code, 1'b0});
        repeat (2) begin
            n = 0;
            last = clockPinOut;
            while (clockPinOut === last && n < 4000) begin
                @(posedge sys_clk);
                #1 n++;
            end
        end
        chk(24'(n), 24'(12 << code));
    endtask
    task automatic test_clock();
        wr(8'h29, 24'hffffff);
        rdChk(8'h29, 24'h00021e);
        chk(clockDividerCodeBad, 1'b1);
        chk(clockPinOutEn, 1'b0);
        wr(8'h23, 24'h000200);
        chk({oscillatorEnable, clockPinOutEn}, 2'b11);
        halfChk(4'h0);
        halfChk(4'h1);
        halfChk(4'h7);
        wr(8'h29, 24'h000000);
        chk(clockPinOutEn, 1'b0);
    endtask
    task automatic test_current();
        logic [5:0] codes [3] = '{6'h3f, 6'h20, 6'h01};
        for (int r = 0; r < 2; r++) begin
            wr(8'h23, 24'(r) << 17);
            chk(24'(highCurrentRange), 24'(r));
            foreach (codes[k]) begin
                @(posedge sys_clk) firstLedCurrentCode <= codes[k];
                #1 chk(firstLedCurrentMilliamp,
                    24'(codes[k] * (r ? 100 : 50) / 63));
            end
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic complete_run();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // the slowest test needs a few thousand cycles; this is ample
    initial begin
        #300000 err_count++;
        complete_run();
    end
    initial begin
        {rst, regWrite, regRead, resultStrobe, threeLedMode} = 5'h1f;
        {regWrite, regRead, resultStrobe, threeLedMode} = 4'h0;
        {dynPowerDownActive, regAddr, regWrData} = 33'h0;
        {secondLedResult, secondAmbientResult, thirdLedResult} = 72'h0;
        firstLedCurrentCode = 6'h00;
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        rdChk(8'h23, 24'h0);
        rdChk(8'h2a, 24'h0);
        test_power();
        test_results();
        test_clock();
        test_current();
        complete_run();
    end
endmodule
